// ===== lcr_gain_ramp.sv
// Gain-reduction ramp for one limiter channel.
// Assumes all inputs come from logic on the same clock.
`timescale 1ns/1ps
module lcr_gain_ramp #(
  parameter int GAIN_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic over,
  input wire logic [31:0] attackCycles,
  input wire logic [31:0] releaseCycles,
  output logic [GAIN_W-1:0] gainCut
);

  if (GAIN_W < 2) begin : gWidthCheck
    $error("lcr_gain_ramp: GAIN_W must be at least 2");
  end

  logic [31:0] stepCount;
  logic [31:0] limit;
  logic stepDue;

  // Pick the step period for the current direction of travel.
  assign limit = over ? attackCycles : releaseCycles;
  assign stepDue = (stepCount + 32'h1 >= limit);

  // Step timer runs only while over is high or the gain cut is nonzero.
  always_ff @(posedge clk) begin
    if (rst || !enable || stepDue) begin
      stepCount <= 32'h0;
    end else if (over || gainCut != '0) begin
      stepCount <= stepCount + 32'h1;
    end else begin
      stepCount <= 32'h0;
    end
  end

  // Gradual attack and release.
  // One eighth dB per period; saturating so a long overload cannot wrap.
  always_ff @(posedge clk) begin
    if (rst || !enable) begin
      gainCut <= '0;
    end else if (stepDue && over && gainCut != '1) begin
      gainCut <= gainCut + 1'b1;
    end else if (stepDue && !over && gainCut != '0) begin
      gainCut <= gainCut - 1'b1;
    end
  end

endmodule : lcr_gain_ramp

// ===== lcr_limiter_asserts.sv
// Port-level checker for the limiter control registers.
// Assumes one core clock and a synchronous, active-high reset.
`timescale 1ns/1ps
module lcr_checker #(
  parameter int GAIN_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic [7:0] supplyLevel,
  input wire logic [7:0] rightKneeVoltage,
  input wire logic [6:0] leftThreshold,
  input wire logic [6:0] rightThreshold,
  input wire logic rightLimiting,
  input wire logic rightMute,
  input wire logic channelLimiterTie,
  input wire logic [GAIN_W-1:0] rightGainCut
);
  logic [7:0] shadow;
  logic offCond;
  logic muteCond;
  logic highCond;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Shadow of the right setup byte, so modes can be judged at the ports.
  always_ff @(posedge clk) begin
    if (rst) begin
      shadow <= 8'ha8;
    end else if (regWrite && regAddr == 8'h11) begin
      shadow <= regWdata;
    end
  end
  // Mode conditions apply only while the tie bit leaves the right alone.
  assign offCond = !shadow[3] && shadow[1:0] == 2'h0;
  assign muteCond = !shadow[3] && shadow[1:0] == 2'h2 &&
    supplyLevel < rightKneeVoltage;
  assign highCond = !shadow[3] && shadow[1:0] == 2'h3 &&
    supplyLevel >= rightKneeVoltage;
  a_rsvd_reads_zero: assert property (
    regRead && regAddr == 8'h0f |=> regRdata[2] == 1'b0)
    else $error("reserved threshold bit read back set");
  a_unmapped_reads_zero: assert property (
    regRead && (regAddr < 8'h0f || regAddr > 8'h11) |=> regRdata == 8'h00)
    else $error("unmapped read returned nonzero");
  a_knee_write_back: assert property (
    regWrite && regAddr == 8'h10 ##1 regRead && regAddr == 8'h10
    |=> regRdata == $past(regWdata, 2))
    else $error("knee register did not return written byte");
  a_tie_follows_write: assert property (
    regWrite && regAddr == 8'h11 |=> channelLimiterTie == shadow[3])
    else $error("tie output differs from written bit");
  a_mode_off_idle: assert property (
    !$past(rst) && $past(offCond) |-> !rightLimiting && !rightMute)
    else $error("right limiter active in off mode");
  a_mute_below_knee: assert property (
    !$past(rst) && $past(muteCond) |-> rightMute)
    else $error("right mute missing below knee");
  a_low_mode_idle: assert property (
    !$past(rst) && $past(highCond) |-> !rightLimiting)
    else $error("right limiter engaged above knee");
  a_threshold_floor: assert property (
    leftThreshold >= 7'h08 && rightThreshold >= 7'h08)
    else $error("threshold below lowest level");
  a_gain_gradual: assert property (
    !$past(rst) && rightGainCut != $past(rightGainCut) |->
    rightGainCut == $past(rightGainCut) + 1'b1 ||
    rightGainCut == $past(rightGainCut) - 1'b1 || rightGainCut == '0)
    else $error("right gain cut jumped");
endmodule : lcr_checker

bind lcr_limiter_control_registers lcr_checker #(.GAIN_W(GAIN_W)) u_chk (
  .clk(clk), .rst(rst), .regWrite(regWrite), .regRead(regRead),
  .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
  .supplyLevel(supplyLevel), .rightKneeVoltage(rightKneeVoltage),
  .leftThreshold(leftThreshold), .rightThreshold(rightThreshold),
  .rightLimiting(rightLimiting), .rightMute(rightMute),
  .channelLimiterTie(channelLimiterTie), .rightGainCut(rightGainCut));

// ===== lcr_limiter_control_registers.sv
// Limiter control registers and decode for both output channels.
// Assumes a byte-wide control port on the core clock, and that the
// neighbouring registers, supply reading and peak levels share that clock.
`timescale 1ns/1ps
module lcr_limiter_control_registers #(
  parameter int GAIN_W = 8,
  parameter int RELEASE_CYC0 = lcr_pkg::RELEASE_CYC0,
  parameter int RELEASE_CYC1 = lcr_pkg::RELEASE_CYC1,
  parameter int RELEASE_CYC2 = lcr_pkg::RELEASE_CYC2,
  parameter int RELEASE_CYC3 = lcr_pkg::RELEASE_CYC3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic [7:0] leftSetup,
  input wire logic [7:0] rightThresholdSlope,
  input wire logic [7:0] rightKneeVoltage,
  input wire logic [7:0] supplyLevel,
  input wire logic [6:0] leftPeak,
  input wire logic [6:0] rightPeak,
  output logic [6:0] leftThreshold,
  output logic [6:0] rightThreshold,
  output logic leftLimiting,
  output logic rightLimiting,
  output logic leftMute,
  output logic rightMute,
  output logic channelLimiterTie,
  output logic [GAIN_W-1:0] leftGainCut,
  output logic [GAIN_W-1:0] rightGainCut
);

  if (RELEASE_CYC0 < 1 || RELEASE_CYC1 < 1 || RELEASE_CYC2 < 1 ||
      RELEASE_CYC3 < 1) begin : gReleaseCheck
    $error("lcr_limiter_control_registers: release counts must be >= 1");
  end

  // Threshold code to quarter volts, piecewise as the steps change.
  function automatic logic [6:0] codeToQv(input logic [4:0] code);
    logic [6:0] c;
    c = {2'b00, code};
    if (code <= lcr_pkg::THR_FINE_START) begin
      codeToQv = lcr_pkg::THR_TOP_QV - (c << 1);
    end else if (code <= lcr_pkg::THR_FINE_END) begin
      codeToQv = lcr_pkg::THR_TOP_QV - 7'(2 * lcr_pkg::THR_FINE_START)
                 - (c - {2'b00, lcr_pkg::THR_FINE_START});
    end else begin
      codeToQv = lcr_pkg::THR_TOP_QV - 7'(2 * lcr_pkg::THR_FINE_START)
                 - 7'(lcr_pkg::THR_FINE_END - lcr_pkg::THR_FINE_START)
                 - ((c - {2'b00, lcr_pkg::THR_FINE_END}) << 1);
    end
  endfunction : codeToQv

  // Effective threshold with optional supply tracking and floor.
  function automatic logic [6:0] trackedQv(input lcr_pkg::lcr_ctl_s ctl,
                                           input logic [7:0] supply);
    logic [6:0] base;
    logic [10:0] cut;
    base = codeToQv(ctl.thrCode);
    cut = 11'h0;
    if (ctl.track && supply < ctl.knee) begin
      cut = 11'(ctl.knee - supply) * 11'({1'b0, ctl.slope} + 3'h1);
    end
    if ({4'h0, base} <= cut + {4'h0, lcr_pkg::THR_FLOOR_QV}) begin
      trackedQv = lcr_pkg::THR_FLOOR_QV;
    end else begin
      trackedQv = base - 7'(cut);
    end
  endfunction : trackedQv

  // Attack step period for a two-bit rate code.
  function automatic logic [31:0] attackCycles(input logic [1:0] code);
    unique case (code)
      2'h0: attackCycles = 32'(lcr_pkg::ATTACK_CYC0);
      2'h1: attackCycles = 32'(lcr_pkg::ATTACK_CYC1);
      2'h2: attackCycles = 32'(lcr_pkg::ATTACK_CYC2);
      2'h3: attackCycles = 32'(lcr_pkg::ATTACK_CYC3);
    endcase
  endfunction : attackCycles

  // Release step period for a two-bit rate code.
  function automatic logic [31:0] releaseCycles(input logic [1:0] code);
    unique case (code)
      2'h0: releaseCycles = 32'(RELEASE_CYC0);
      2'h1: releaseCycles = 32'(RELEASE_CYC1);
      2'h2: releaseCycles = 32'(RELEASE_CYC2);
      2'h3: releaseCycles = 32'(RELEASE_CYC3);
    endcase
  endfunction : releaseCycles

  // Limiter engaged for the mode and supply condition.
  function automatic logic modeActive(input logic [1:0] mode,
                                      input logic below);
    modeActive = (mode == lcr_pkg::MODE_ON) ||
                 (mode == lcr_pkg::MODE_ON_LOW && below);
  endfunction : modeActive

  logic [4:0] leftThresholdCode;
  logic [1:0] leftSlope;
  logic [7:0] leftKneeVoltage;
  logic [1:0] rightReleaseRate;
  logic [1:0] rightAttackRate;
  logic rightTrack;
  logic [1:0] rightLimiterSelect;
  logic hitThr;
  logic hitKnee;
  logic hitSetup;

  assign hitThr = regAddr == lcr_pkg::ADDR_LEFT_THRESHOLD_SLOPE;
  assign hitKnee = regAddr == lcr_pkg::ADDR_LEFT_KNEE_VOLTAGE;
  assign hitSetup = regAddr == lcr_pkg::ADDR_RIGHT_LIMIT_SETUP;

  // Reserved bit is never stored, so writes to it vanish.
  always_ff @(posedge clk) begin
    if (rst) begin
      leftThresholdCode <=
        lcr_pkg::RST_LEFT_THRESHOLD_SLOPE[lcr_pkg::THR_MSB:lcr_pkg::THR_LSB];
      leftSlope <=
        lcr_pkg::RST_LEFT_THRESHOLD_SLOPE[lcr_pkg::SLOPE_MSB:
                                          lcr_pkg::SLOPE_LSB];
    end else if (regWrite && hitThr) begin
      leftThresholdCode <= regWdata[lcr_pkg::THR_MSB:lcr_pkg::THR_LSB];
      leftSlope <= regWdata[lcr_pkg::SLOPE_MSB:lcr_pkg::SLOPE_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      leftKneeVoltage <= lcr_pkg::RST_LEFT_KNEE_VOLTAGE;
    end else if (regWrite && hitKnee) begin
      leftKneeVoltage <= regWdata;
    end
  end

  // Right setup storage with its reset value.
  always_ff @(posedge clk) begin
    if (rst) begin
      rightReleaseRate <=
        lcr_pkg::RST_RIGHT_LIMIT_SETUP[lcr_pkg::REL_MSB:lcr_pkg::REL_LSB];
      rightAttackRate <=
        lcr_pkg::RST_RIGHT_LIMIT_SETUP[lcr_pkg::ATK_MSB:lcr_pkg::ATK_LSB];
      channelLimiterTie <= lcr_pkg::RST_RIGHT_LIMIT_SETUP[lcr_pkg::TIE_BIT];
      rightTrack <= lcr_pkg::RST_RIGHT_LIMIT_SETUP[lcr_pkg::TRACK_BIT];
      rightLimiterSelect <=
        lcr_pkg::RST_RIGHT_LIMIT_SETUP[lcr_pkg::MODE_MSB:lcr_pkg::MODE_LSB];
    end else if (regWrite && hitSetup) begin
      rightReleaseRate <= regWdata[lcr_pkg::REL_MSB:lcr_pkg::REL_LSB];
      rightAttackRate <= regWdata[lcr_pkg::ATK_MSB:lcr_pkg::ATK_LSB];
      channelLimiterTie <= regWdata[lcr_pkg::TIE_BIT];
      rightTrack <= regWdata[lcr_pkg::TRACK_BIT];
      rightLimiterSelect <= regWdata[lcr_pkg::MODE_MSB:lcr_pkg::MODE_LSB];
    end
  end

  // Read data is registered; unmapped offsets answer zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      if (hitThr) begin
        regRdata <= {leftThresholdCode, 1'b0, leftSlope};
      end else if (hitKnee) begin
        regRdata <= leftKneeVoltage;
      end else if (hitSetup) begin
        regRdata <= {rightReleaseRate, rightAttackRate, channelLimiterTie,
                     rightTrack, rightLimiterSelect};
      end else begin
        regRdata <= 8'h00;
      end
    end
  end

  lcr_pkg::lcr_ctl_s leftCtl;
  lcr_pkg::lcr_ctl_s rightOwnCtl;
  lcr_pkg::lcr_ctl_s rightCtl;

  // Left setup fields share the right encodings.
  always_comb begin
    leftCtl.relRate = leftSetup[lcr_pkg::REL_MSB:lcr_pkg::REL_LSB];
    leftCtl.attack = leftSetup[lcr_pkg::ATK_MSB:lcr_pkg::ATK_LSB];
    leftCtl.track = leftSetup[lcr_pkg::TRACK_BIT];
    leftCtl.mode = leftSetup[lcr_pkg::MODE_MSB:lcr_pkg::MODE_LSB];
    leftCtl.thrCode = leftThresholdCode;
    leftCtl.slope = leftSlope;
    leftCtl.knee = leftKneeVoltage;
  end

  // Right channel's own controls; the threshold and knee live elsewhere.
  always_comb begin
    rightOwnCtl.relRate = rightReleaseRate;
    rightOwnCtl.attack = rightAttackRate;
    // Tracking flag; when clear the code stands as programmed.
    rightOwnCtl.track = rightTrack;
    rightOwnCtl.mode = rightLimiterSelect;
    rightOwnCtl.thrCode =
      rightThresholdSlope[lcr_pkg::THR_MSB:lcr_pkg::THR_LSB];
    rightOwnCtl.slope =
      rightThresholdSlope[lcr_pkg::SLOPE_MSB:lcr_pkg::SLOPE_LSB];
    rightOwnCtl.knee = rightKneeVoltage;
  end

  // Tied channels both follow the left controls.
  assign rightCtl = channelLimiterTie ? leftCtl : rightOwnCtl;

  logic leftBelow;
  logic rightBelow;
  assign leftBelow = supplyLevel < leftCtl.knee;
  assign rightBelow = supplyLevel < rightCtl.knee;

  // Thresholds registered so the outputs come from flip-flops.
  always_ff @(posedge clk) begin
    if (rst) begin
      leftThreshold <= lcr_pkg::THR_TOP_QV;
      rightThreshold <= lcr_pkg::THR_TOP_QV;
    end else begin
      leftThreshold <= trackedQv(leftCtl, supplyLevel);
      rightThreshold <= trackedQv(rightCtl, supplyLevel);
    end
  end

  // Engage and mute decode; mute does not also engage the limiter.
  always_ff @(posedge clk) begin
    if (rst) begin
      leftLimiting <= 1'b0;
      rightLimiting <= 1'b0;
      leftMute <= 1'b0;
      rightMute <= 1'b0;
    end else begin
      leftLimiting <= modeActive(leftCtl.mode, leftBelow);
      rightLimiting <= modeActive(rightCtl.mode, rightBelow);
      leftMute <= leftCtl.mode == lcr_pkg::MODE_MUTE_LOW && leftBelow;
      rightMute <= rightCtl.mode == lcr_pkg::MODE_MUTE_LOW && rightBelow;
    end
  end

  // Gain ramps compare peaks against the registered thresholds, which
  // costs one cycle of lag but keeps the compare path short.
  lcr_gain_ramp #(
    .GAIN_W(GAIN_W)
  ) uLeftRamp (
    .clk(clk),
    .rst(rst),
    .enable(leftLimiting),
    .over(leftPeak > leftThreshold),
    .attackCycles(attackCycles(leftCtl.attack)),
    .releaseCycles(releaseCycles(leftCtl.relRate)),
    .gainCut(leftGainCut)
  );

  lcr_gain_ramp #(
    .GAIN_W(GAIN_W)
  ) uRightRamp (
    .clk(clk),
    .rst(rst),
    .enable(rightLimiting),
    .over(rightPeak > rightThreshold),
    .attackCycles(attackCycles(rightCtl.attack)),
    .releaseCycles(releaseCycles(rightCtl.relRate)),
    .gainCut(rightGainCut)
  );

endmodule : lcr_limiter_control_registers

// ===== lcr_pkg.sv
// Constants, field layouts and control bundles for the limiter control
// registers. Assumes a byte-wide control port and a 125 MHz core clock.
package lcr_pkg;

  // Register offsets on the control port.
  localparam logic [7:0] ADDR_LEFT_THRESHOLD_SLOPE = 8'h0f;
  localparam logic [7:0] ADDR_LEFT_KNEE_VOLTAGE = 8'h10;
  localparam logic [7:0] ADDR_RIGHT_LIMIT_SETUP = 8'h11;

  // Reset values of the three registers.
  localparam logic [7:0] RST_LEFT_THRESHOLD_SLOPE = 8'h51;
  localparam logic [7:0] RST_LEFT_KNEE_VOLTAGE = 8'h22;
  localparam logic [7:0] RST_RIGHT_LIMIT_SETUP = 8'ha8;

  // Field positions of the threshold/slope register.
  localparam int THR_MSB = 7;
  localparam int THR_LSB = 3;
  localparam int RSVD_BIT = 2;
  localparam int SLOPE_MSB = 1;
  localparam int SLOPE_LSB = 0;

  // Field positions of a setup register.
  localparam int REL_MSB = 7;
  localparam int REL_LSB = 6;
  localparam int ATK_MSB = 5;
  localparam int ATK_LSB = 4;
  localparam int TIE_BIT = 3;
  localparam int TRACK_BIT = 2;
  localparam int MODE_MSB = 1;
  localparam int MODE_LSB = 0;

  // Threshold levels in quarter volts: code 0, 13, 19, 31.
  localparam logic [6:0] THR_TOP_QV = 7'h40;
  localparam logic [6:0] THR_FLOOR_QV = 7'h08;
  localparam logic [4:0] THR_FINE_START = 5'h0d;
  localparam logic [4:0] THR_FINE_END = 5'h13;

  // Limiter modes.
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ON = 2'h1;
  localparam logic [1:0] MODE_MUTE_LOW = 2'h2;
  localparam logic [1:0] MODE_ON_LOW = 2'h3;

  // Timing: clock rate and gain steps of one eighth dB.
  localparam int CLK_MHZ = 125;
  localparam int STEPS_PER_DB = 8;
  localparam int ATTACK_US0 = 120;
  localparam int ATTACK_US1 = 60;
  localparam int ATTACK_US2 = 30;
  localparam int ATTACK_US3 = 20;
  localparam int RELEASE_MS0 = 3200;
  localparam int RELEASE_MS1 = 1600;
  localparam int RELEASE_MS2 = 1200;
  localparam int RELEASE_MS3 = 800;
  localparam int ATTACK_CYC0 = ATTACK_US0 * CLK_MHZ / STEPS_PER_DB;
  localparam int ATTACK_CYC1 = ATTACK_US1 * CLK_MHZ / STEPS_PER_DB;
  localparam int ATTACK_CYC2 = ATTACK_US2 * CLK_MHZ / STEPS_PER_DB;
  localparam int ATTACK_CYC3 = ATTACK_US3 * CLK_MHZ / STEPS_PER_DB;
  localparam int RELEASE_CYC0 = RELEASE_MS0 * 1000 / STEPS_PER_DB * CLK_MHZ;
  localparam int RELEASE_CYC1 = RELEASE_MS1 * 1000 / STEPS_PER_DB * CLK_MHZ;
  localparam int RELEASE_CYC2 = RELEASE_MS2 * 1000 / STEPS_PER_DB * CLK_MHZ;
  localparam int RELEASE_CYC3 = RELEASE_MS3 * 1000 / STEPS_PER_DB * CLK_MHZ;

  // One channel's limiter controls, as used after link selection.
  typedef struct packed {
    logic [1:0] relRate;
    logic [1:0] attack;
    logic track;
    logic [1:0] mode;
    logic [4:0] thrCode;
    logic [1:0] slope;
    logic [7:0] knee;
  } lcr_ctl_s;

endpackage : lcr_pkg

// ===== tb_top.sv
// Self-checking bench for the limiter control registers.
// Assumes the checker is bound in; release periods are shortened.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic regWrite = 1'b0, regRead = 1'b0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
  logic [7:0] leftSetup = 8'h00, rightThresholdSlope = 8'ha0;
  logic [7:0] rightKneeVoltage = 8'h22, supplyLevel = 8'h40;
  logic [6:0] leftPeak = 7'h7f, rightPeak = 7'h7f;
  logic [6:0] leftThreshold, rightThreshold;
  logic leftLimiting, rightLimiting, leftMute, rightMute, channelLimiterTie;
  logic [7:0] leftGainCut, rightGainCut;
  int failures = 0;
  int compares = 0;
  localparam logic [7:0] ROWA [5] = '{8'h0f, 8'h0f, 8'h10, 8'h11, 8'h3c};
  localparam logic [7:0] ROWD [5] = '{8'hff, 8'h04, 8'ha5, 8'h57, 8'hff};
  localparam logic [7:0] ROWE [5] = '{8'hfb, 8'h00, 8'ha5, 8'h57, 8'h00};

  always #4 clk = ~clk;

  lcr_limiter_control_registers #(.RELEASE_CYC0(40), .RELEASE_CYC1(20),
    .RELEASE_CYC2(15), .RELEASE_CYC3(10)) DUT (.clk(clk), .rst(rst),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .leftSetup(leftSetup),
    .rightThresholdSlope(rightThresholdSlope), .supplyLevel(supplyLevel),
    .rightKneeVoltage(rightKneeVoltage), .leftPeak(leftPeak),
    .rightPeak(rightPeak), .leftThreshold(leftThreshold),
    .rightThreshold(rightThreshold), .leftLimiting(leftLimiting),
    .rightLimiting(rightLimiting), .leftMute(leftMute),
    .rightMute(rightMute), .channelLimiterTie(channelLimiterTie),
    .leftGainCut(leftGainCut), .rightGainCut(rightGainCut));

  // Expected threshold level in quarter volts: coarse, fine, then coarse steps.
  function automatic logic [7:0] qv(int c);
    if (c <= 13) return 8'(64 - 2 * c);
    if (c <= 19) return 8'(51 - c);
    return 8'(70 - 2 * c);
  endfunction : qv

  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    compares++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Optional write, then a read of the same place on the very next edge.
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d, logic [7:0] e);
    regWrite = w;
    regAddr = a;
    regWdata = d;
    @(negedge clk);
    regWrite = 1'b0;
    regRead = 1'b1;
    @(negedge clk);
    regRead = 1'b0;
    @(negedge clk);
    chk("readback", e, regRdata);
  endtask : acc

  // Write, then leave three edges so the decode outputs have settled.
  task automatic wr(logic [7:0] a, logic [7:0] d);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge clk);
    regWrite = 1'b0;
    repeat (3) @(negedge clk);
  endtask : wr

  task automatic complete_run();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  // A hang is cut short well inside the cycle budget.
  initial begin
    #400000;
    failures++;
    complete_run();
  end

  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    // Reset state of the registers and the tie output.
    chk("rdata", 8'h00, regRdata);
    chk("tie", 8'h01, {7'h00, channelLimiterTie});
    acc(1'b0, 8'h0f, 8'h00, 8'h51);
    acc(1'b0, 8'h10, 8'h00, 8'h22);
    acc(1'b0, 8'h11, 8'h00, 8'ha8);
    chk("left thr", 8'h2c, {1'b0, leftThreshold});
    $display("test reset done");
    for (int i = 0; i < 5; i++) acc(1'b1, ROWA[i], ROWD[i], ROWE[i]);
    $display("test rows done");
    // Every threshold code with tracking off.
    for (int c = 0; c < 32; c++) begin
      wr(8'h0f, {c[4:0], 3'h1});
      chk("left thr", qv(c), {1'b0, leftThreshold});
    end
    // Slope ratios below the knee, then the floor.
    wr(8'h10, 8'h22);
    leftSetup = 8'h04;
    supplyLevel = 8'h20;
    for (int s = 0; s < 4; s++) begin
      wr(8'h0f, {5'h0a, 1'b0, s[1:0]});
      chk("left track", 8'(42 - 2 * s), {1'b0, leftThreshold});
    end
    supplyLevel = 8'h00;
    wr(8'h0f, 8'h53);
    chk("floor", 8'h08, {1'b0, leftThreshold});
    leftSetup = 8'h00;
    $display("test threshold done");
    // Right tracking on, then off.
    supplyLevel = 8'h10;
    wr(8'h11, 8'h04);
    chk("right track", 8'h0c, {1'b0, rightThreshold});
    wr(8'h11, 8'h00);
    chk("right fixed", 8'h1e, {1'b0, rightThreshold});
    // Every right mode below and above the knee.
    for (int m = 0; m < 4; m++) begin
      for (int b = 0; b < 2; b++) begin
        supplyLevel = b[0] ? 8'h10 : 8'h40;
        wr(8'h11, {6'h00, m[1:0]});
        chk("limit", {7'h00, m == 1 || (m == 3 && b == 1)},
          {7'h00, rightLimiting});
        chk("mute", {7'h00, m == 2 && b == 1}, {7'h00, rightMute});
      end
    end
    $display("test modes done");
    // Tied channels follow the left controls.
    wr(8'h0f, 8'h51);
    leftSetup = 8'h01;
    wr(8'h11, 8'h08);
    chk("tied thr", 8'h2c, {1'b0, rightThreshold});
    chk("tied limit", 8'h01, {7'h00, rightLimiting});
    chk("left limit", 8'h01, {7'h00, leftLimiting});
    // Left mute and low-only modes; the supply sits below the knee.
    leftSetup = 8'h02;
    repeat (2) @(negedge clk);
    chk("left mute", 8'h01, {7'h00, leftMute});
    chk("tied mute", 8'h01, {7'h00, rightMute});
    leftSetup = 8'h03;
    repeat (2) @(negedge clk);
    chk("left low", 8'h01, {7'h00, leftLimiting});
    chk("left unmute", 8'h00, {7'h00, leftMute});
    leftSetup = 8'h00;
    $display("test tie done");
    // Attack steps on both channels, then a fast right release back to zero.
    wr(8'h11, 8'hf0);
    chk("gain off", 8'h00, rightGainCut);
    chk("left gain off", 8'h00, leftGainCut);
    leftSetup = 8'h31;
    wr(8'h11, 8'hf1);
    repeat (296) @(negedge clk);
    chk("attack early", 8'h00, rightGainCut);
    chk("left early", 8'h00, leftGainCut);
    repeat (30) @(negedge clk);
    chk("attack step", 8'h01, rightGainCut);
    chk("left step", 8'h01, leftGainCut);
    repeat (300) @(negedge clk);
    chk("attack two", 8'h02, rightGainCut);
    rightPeak = 7'h00;
    repeat (12) @(negedge clk);
    chk("release step", 8'h01, rightGainCut);
    for (int n = 0; n < 40 && rightGainCut !== 8'h00; n++) @(negedge clk);
    chk("release", 8'h00, rightGainCut);
    leftSetup = 8'h00;
    $display("test gain done");
    // A reset in mid-run brings the right setup and left threshold registers back to their defaults.
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk("mid rdata", 8'h00, regRdata);
    chk("mid gain", 8'h00, rightGainCut);
    chk("mid tie", 8'h01, {7'h00, channelLimiterTie});
    acc(1'b0, 8'h11, 8'h00, 8'ha8);
    acc(1'b0, 8'h0f, 8'h00, 8'h51);
    $display("test mid reset done");
    complete_run();
  end
endmodule : tb_top
